// ### hw/omf_pkg.sv
package omf_pkg;
  // ***************************************************
  // register map
  // ***************************************************
  localparam logic [31:0] FAST_CTRL_ADDR = 32'h0003_0074;
  localparam logic [31:0] SLOW_CTRL_ADDR = 32'h0003_0078;
  localparam logic [31:0] STATUS_ADDR = 32'h0003_0080;
  // ***************************************************
  // fields
  // ***************************************************
  localparam int FAST_EN_BIT = 0;
  localparam int FAST_TH_LSB = 1;
  localparam int FAST_TH_W = 17;
  localparam int SLOW_EN_BIT = 0;
  localparam int SLOW_IRQ_BIT = 1;
  localparam int SLOW_TH_LSB = 2;
  localparam int SLOW_TH_W = 5;
  localparam int STAT_FAST_BIT = 0;
  localparam int STAT_SLOW_BIT = 1;
  // ***************************************************
  // reset values
  // ***************************************************
  localparam logic [FAST_TH_W-1:0] FAST_TH_RST = 17'h000FF;
  localparam logic [SLOW_TH_W-1:0] SLOW_TH_RST = 5'h03;
  // ***************************************************
  // supervision counter widths
  // ***************************************************
  localparam int SLOW_SUPV_W = 8;
  localparam int FAST_SUPV_W = 24;
endpackage

// ### hw/omf_toggle_sync.sv
`timescale 1ns/1ps
module omf_toggle_sync
  import omf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic srcToggle,
  output logic pulse
);
  logic stage1;
  logic stage2;
  logic stage3;

  // ***************************************************
  // two flops then edge of toggle
  // ***************************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end
    else
    begin
      stage1 <= srcToggle;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign pulse = stage2 ^ stage3;
endmodule // omf_toggle_sync

// ### hw/omf_supv_counter.sv
`timescale 1ns/1ps
module omf_supv_counter
  import omf_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic enable,
  input wire logic tick,
  input wire logic clear,
  output logic overflow
);
  logic [WIDTH-1:0] count;

  // ***************************************************
  // counts ticks, clear wins, pulse on wrap
  // ***************************************************
  always_ff @(posedge mclk)
  begin
    if (rst || !enable || clear)
    begin
      count <= '0;
      overflow <= 1'b0;
    end
    else if (tick)
    begin
      count <= count + 1'b1;
      overflow <= &count;
    end
    else
    begin
      overflow <= 1'b0;
    end
  end
endmodule // omf_supv_counter

// ### hw/omf_monitor.sv
// How it works
// - fast threshold, reset 255, clears slow counter
// - slow counter overflow means reset
// - fast monitor enable bit 0; failure resets
// - slow threshold bits 6:2, reset 3, clears fast
// - fast counter overflow means failure
// - slow monitor enable bit 0; failure interrupts, or resets if irq disabled
// - irq enable bit 1 gates interrupt
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module omf_monitor
  import omf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic fastOscIn,
  input wire logic slowOscIn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic deviceResetReq,
  output logic slowFailIrq
);
  logic [FAST_TH_W-1:0] fastThreshold;
  logic fastMonitorEnable;
  logic [SLOW_TH_W-1:0] slowThreshold;
  logic slowIrqEnable;
  logic slowMonitorEnable;
  logic fastFailSeen;
  logic slowFailSeen;
  logic fastOscLast;
  logic slowOscLast;
  logic fastTick;
  logic slowTick;
  logic [FAST_TH_W-1:0] fastThCount;
  logic [SLOW_TH_W-1:0] slowThCount;
  logic fastClearToggle;
  logic slowClearToggle;
  logic fastClearAtSlow;
  logic slowClearAtFast;
  logic fastOscFail;
  logic slowOscFail;
  logic wrEn;
  logic rdSetup;

  function automatic logic isMapped(input logic [31:0] a);
    isMapped = (a == FAST_CTRL_ADDR) || (a == SLOW_CTRL_ADDR) ||
               (a == STATUS_ADDR);
  endfunction

  function automatic logic writeHit(input logic [31:0] a);
    writeHit = wrEn && (paddr == a);
  endfunction

  function automatic logic atThreshold(input logic [FAST_TH_W-1:0] count,
                                       input logic [FAST_TH_W-1:0] limit);
    atThreshold = (count + 1'b1) >= limit;
  endfunction

  assign wrEn = psel && penable && pready && pwrite && isMapped(paddr);
  assign rdSetup = psel && !penable;

  // ***************************************************
  // apb handshake, one wait-free access cycle
  // ***************************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= rdSetup;
      pslverr <= rdSetup && !isMapped(paddr);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (rdSetup && !pwrite)
    begin
      if (paddr == FAST_CTRL_ADDR)
      begin
        prdata <= '0;
        prdata[FAST_EN_BIT] <= fastMonitorEnable;
        prdata[FAST_TH_LSB +: FAST_TH_W] <= fastThreshold;
      end
      else if (paddr == SLOW_CTRL_ADDR)
      begin
        prdata <= '0;
        prdata[SLOW_EN_BIT] <= slowMonitorEnable;
        prdata[SLOW_IRQ_BIT] <= slowIrqEnable;
        prdata[SLOW_TH_LSB +: SLOW_TH_W] <= slowThreshold;
      end
      else if (paddr == STATUS_ADDR)
      begin
        prdata <= '0;
        prdata[STAT_FAST_BIT] <= fastFailSeen;
        prdata[STAT_SLOW_BIT] <= slowFailSeen;
      end
      else
      begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ***************************************************
  // control registers
  // ***************************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      fastThreshold <= FAST_TH_RST;
      fastMonitorEnable <= 1'b0;
    end
    else if (writeHit(FAST_CTRL_ADDR))
    begin
      fastThreshold <= pwdata[FAST_TH_LSB +: FAST_TH_W];
      fastMonitorEnable <= pwdata[FAST_EN_BIT];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      slowThreshold <= SLOW_TH_RST;
      slowIrqEnable <= 1'b0;
      slowMonitorEnable <= 1'b0;
    end
    else if (writeHit(SLOW_CTRL_ADDR))
    begin
      slowThreshold <= pwdata[SLOW_TH_LSB +: SLOW_TH_W];
      slowIrqEnable <= pwdata[SLOW_IRQ_BIT];
      slowMonitorEnable <= pwdata[SLOW_EN_BIT];
    end
  end

  // ***************************************************
  // failure status, write one to clear, set wins
  // ***************************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      fastFailSeen <= 1'b0;
    end
    else if (fastOscFail)
    begin
      fastFailSeen <= 1'b1;
    end
    else if (writeHit(STATUS_ADDR) && pwdata[STAT_FAST_BIT])
    begin
      fastFailSeen <= 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      slowFailSeen <= 1'b0;
    end
    else if (slowOscFail)
    begin
      slowFailSeen <= 1'b1;
    end
    else if (writeHit(STATUS_ADDR) && pwdata[STAT_SLOW_BIT])
    begin
      slowFailSeen <= 1'b0;
    end
  end

  // ***************************************************
  // oscillator edges
  // ***************************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      fastOscLast <= 1'b0;
      slowOscLast <= 1'b0;
    end
    else
    begin
      fastOscLast <= fastOscIn;
      slowOscLast <= slowOscIn;
    end
  end

  assign fastTick = fastOscIn && !fastOscLast;
  assign slowTick = slowOscIn && !slowOscLast;

  // ***************************************************
  // fast-side threshold, sends clear to slow side
  // ***************************************************
  always_ff @(posedge mclk)
  begin
    if (rst || !fastMonitorEnable)
    begin
      fastThCount <= '0;
      fastClearToggle <= 1'b0;
    end
    else if (fastTick)
    begin
      if (atThreshold(fastThCount, fastThreshold))
      begin
        fastThCount <= '0;
        fastClearToggle <= !fastClearToggle;
      end
      else
      begin
        fastThCount <= fastThCount + 1'b1;
      end
    end
  end

  // ***************************************************
  // slow-side threshold, sends clear to fast side
  // ***************************************************
  always_ff @(posedge mclk)
  begin
    if (rst || !slowMonitorEnable)
    begin
      slowThCount <= '0;
      slowClearToggle <= 1'b0;
    end
    else if (slowTick)
    begin
      if (atThreshold({12'h000, slowThCount},
                      {12'h000, slowThreshold}))
      begin
        slowThCount <= '0;
        slowClearToggle <= !slowClearToggle;
      end
      else
      begin
        slowThCount <= slowThCount + 1'b1;
      end
    end
  end

  // ***************************************************
  // crossings and supervision counters
  // ***************************************************
  omf_toggle_sync uFastToSlow (
    .mclk(mclk),
    .rst(rst),
    .srcToggle(fastClearToggle),
    .pulse(fastClearAtSlow)
  );

  omf_toggle_sync uSlowToFast (
    .mclk(mclk),
    .rst(rst),
    .srcToggle(slowClearToggle),
    .pulse(slowClearAtFast)
  );

  omf_supv_counter #(.WIDTH(SLOW_SUPV_W)) uSlowSupv (
    .mclk(mclk),
    .rst(rst),
    .enable(fastMonitorEnable),
    .tick(slowTick),
    .clear(fastClearAtSlow),
    .overflow(fastOscFail)
  );

  omf_supv_counter #(.WIDTH(FAST_SUPV_W)) uFastSupv (
    .mclk(mclk),
    .rst(rst),
    .enable(slowMonitorEnable),
    .tick(fastTick),
    .clear(slowClearAtFast),
    .overflow(slowOscFail)
  );

  // ***************************************************
  // failure outputs
  // ***************************************************
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      deviceResetReq <= 1'b0;
    end
    else
    begin
      deviceResetReq <= fastOscFail ||
                        (slowOscFail && !slowIrqEnable);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      slowFailIrq <= 1'b0;
    end
    else
    begin
      slowFailIrq <= slowOscFail && slowIrqEnable;
    end
  end
endmodule // omf_monitor

// ### tb/omf_monitor_assertions.sv
`timescale 1ns/1ps
module omf_monitor_chk
  import omf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic deviceResetReq,
  input wire logic slowFailIrq
);
  // ***************************************************
  // bus and failure output checks
  // ***************************************************
  logic setup;
  logic unmapped;
  logic irqOn;
  assign setup = psel && !penable;
  assign unmapped = paddr != FAST_CTRL_ADDR && paddr != SLOW_CTRL_ADDR
    && paddr != STATUS_ADDR;
  always_ff @(posedge mclk)
    if (rst)
      irqOn <= 1'h0;
    else if (psel && penable && pready && pwrite && paddr == SLOW_CTRL_ADDR)
      irqOn <= pwdata[SLOW_IRQ_BIT];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ready_after_setup_a:
    assert property (setup |=> pready) else $error("ready missing");
  ready_needs_setup_a:
    assert property (pready |-> $past(setup)) else $error("stray ready");
  error_unmapped_a:
    assert property (setup && unmapped |=> pslverr)
      else $error("unmapped access not refused");
  unmapped_read_zero_a:
    assert property (setup && unmapped && !pwrite |=> prdata == 32'h0)
      else $error("unmapped read not zero");
  no_error_mapped_a:
    assert property (setup && !unmapped |=> !pslverr)
      else $error("mapped access refused");
  reset_pulse_one_a:
    assert property (deviceResetReq |=> !deviceResetReq)
      else $error("reset request too long");
  irq_pulse_one_a:
    assert property (slowFailIrq |=> !slowFailIrq) else $error("irq too long");
  irq_gated_a:
    assert property (slowFailIrq |-> $past(irqOn))
      else $error("irq while masked");
  status_spare_zero_a:
    assert property (setup && !pwrite && paddr == STATUS_ADDR
      |=> prdata[31:2] == 30'h0) else $error("status spare bits set");
endmodule // omf_monitor_chk
bind omf_monitor omf_monitor_chk omf_monitor_chk_inst (.mclk(mclk),
  .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .deviceResetReq(deviceResetReq),
  .slowFailIrq(slowFailIrq));

// ### tb/tb_omf_monitor.sv
`timescale 1ns/1ps
module tb_omf_monitor
  import omf_pkg::*;
;
  // ***************************************************
  // bench
  // ***************************************************
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic fastOscIn = 1'h0;
  logic slowOscIn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic deviceResetReq;
  logic slowFailIrq;
  logic [31:0] rd;
  logic err;
  int failCount = 0;
  int nCompared = 0;
  int resets = 0;
  int irqs = 0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) resets += (deviceResetReq === 1'h1);
  always @(posedge mclk) irqs += (slowFailIrq === 1'h1);
  omf_monitor omf_monitor_inst (.mclk(mclk), .rst(rst),
    .fastOscIn(fastOscIn), .slowOscIn(slowOscIn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .deviceResetReq(deviceResetReq), .slowFailIrq(slowFailIrq));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      failCount++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do
    begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) failCount++;
    @(posedge mclk);
  endtask
  // slow period four cycles, fast toggles every cycle when on
  task automatic run(input int n, input logic fastOn);
    for (int i = 0; i < 4 * n; i++)
    begin
      @(posedge mclk);
      fastOscIn <= fastOn & ~fastOscIn;
      if (i[0]) slowOscIn <= ~slowOscIn;
    end
  endtask
  task automatic t_regs;
    apb(1'h0, FAST_CTRL_ADDR, 32'h0);
    check(rd, {14'h0, FAST_TH_RST, 1'h0});
    apb(1'h0, SLOW_CTRL_ADDR, 32'h0);
    check(rd, {25'h0, SLOW_TH_RST, 2'h0});
    apb(1'h1, FAST_CTRL_ADDR, 32'h0003_FFFF);
    apb(1'h0, FAST_CTRL_ADDR, 32'h0);
    check(rd, 32'h0003_FFFF);
    apb(1'h1, SLOW_CTRL_ADDR, 32'h7F);
    apb(1'h0, SLOW_CTRL_ADDR, 32'h0);
    check(rd, 32'h0000_007F);
    check({31'h0, err}, 32'h0);
    apb(1'h0, 32'h0003_007C, 32'h0);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h1);
  endtask
  task automatic t_fail;
    apb(1'h1, FAST_CTRL_ADDR, 32'h8);
    apb(1'h1, SLOW_CTRL_ADDR, 32'h0);
    run(300, 1'h0);
    check(resets, 0);
    apb(1'h1, FAST_CTRL_ADDR, 32'h9);
    apb(1'h1, SLOW_CTRL_ADDR, 32'hF);
    run(300, 1'h1);
    check(resets, 0);
    run(262, 1'h0);
    repeat (5) @(posedge mclk);
    check(resets, 1);
    check(irqs, 0);
    apb(1'h0, STATUS_ADDR, 32'h0);
    check(rd, 32'h1);
    apb(1'h1, STATUS_ADDR, 32'h1);
    apb(1'h0, STATUS_ADDR, 32'h0);
    check(rd, 32'h0);
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #200000;
    failCount++;
    wrap_up;
  end
  initial
  begin
    repeat (3) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    t_regs;
    t_fail;
    wrap_up;
  end
endmodule // tb_omf_monitor
